// ==== rtl/contact_input_map.svh ====
// register map, field layout, reset values and timing of the contact input block
// Functional notes
// R01: output three polarity selectable, default closed
// R02: output three alarm number 1..36, default 1
// R03: comm mode local, contact or serial; local default
// R04: input one level run/stop, input two unused
// R05: level run/stop: run while input asserted
// R06: toggle run/stop: flip state on each release
// R07: partner holds toggle input at least 300 ms
// R08: input two level remote: remote while asserted
// R09: input two toggle remote: flip on release
// R10: supervision starts after read delay, default zero
// R11: switch off after continuous off time
// R12: switch off raises alarm 32, action configurable
// R13: run/stop stop gives no later switch alarm
// R14: supervise only while running
// R15: no run function means no contact run control
// R16: switch one only local, modbus, simple one
// R17: either switch off raises the alarm
// R18: switch normally open or closed per input
// R19: inputs synchronised, times counted in ms ticks
// R20: off count restarts when switch returns on
`ifndef CONTACT_INPUT_MAP_SVH
`define CONTACT_INPUT_MAP_SVH

`define OFS_CFG        12'h000
`define OFS_OUT3       12'h004
`define OFS_TIMERS     12'h008
`define OFS_CMD        12'h00c
`define OFS_STATUS     12'h010

`define CFG_RST        12'h040
`define OUT3_SEL_LO    0
`define OUT3_SEL_HI    5
`define OUT3_POL_BIT   8
`define OUT3_FUNC_BIT  12
`define SEL_RST        6'h01
`define SEL_FIRST      6'h01
`define SEL_LAST       6'h24
`define POL_RST        1'b1
`define ALARM_SWITCH   6'h20
`define TIMER_RST      32'h0000_0000
`define CMD_CLR_BIT    0

`define CLK_NS         20
`define MS_NS          1000000
`define HOLD_MS        16'h012c

`endif

// ==== rtl/contact_input_pkg.sv ====
// types shared by the contact input block
package contact_input_pkg;

    typedef enum logic [2:0] {
        FN_OFF       = 3'h0,
        FN_RUN_LEVEL = 3'h1,
        FN_RUN_TOG   = 3'h2,
        FN_SW_NO     = 3'h3,
        FN_SW_NC     = 3'h4,
        FN_RMT_LEVEL = 3'h5,
        FN_RMT_TOG   = 3'h6
    } in_func_t;

    typedef enum logic [1:0] {
        LOCAL_COMM_MODE   = 2'h0,
        CONTACT_COMM_MODE = 2'h1,
        SERIAL_COMM_MODE  = 2'h2
    } comm_mode_t;

    typedef enum logic [1:0] {
        PROTO_MODBUS  = 2'h0,
        PROTO_SIMPLE1 = 2'h1,
        PROTO_SIMPLE2 = 2'h2
    } proto_t;

    typedef enum logic [1:0] {
        ACT_STOP     = 2'h0,
        ACT_CONTINUE = 2'h1,
        ACT_NONE     = 2'h2
    } action_t;

    typedef struct packed {
        in_func_t   in2_func;
        in_func_t   in1_func;
        comm_mode_t comm;
        proto_t     proto;
        action_t    action;
    } cfg_t;

    typedef enum logic [2:0] {
        ST_STOP  = 3'b001,
        ST_DELAY = 3'b010,
        ST_SUPV  = 3'b100
    } run_state_t;

endpackage

// ==== rtl/contact_input_run_control.sv ====
// contact input run/stop, remote select and switch supervision, APB slave
`timescale 1ns/1ps
`include "contact_input_map.svh"

module contact_input_run_control #(
    parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // contact pins
    input  wire logic [1:0]  contact_in,
    // state outputs
    output logic             running,
    output logic             contact_remote_state,
    output logic             switch_detect_alarm,
    output logic             contact_out3
);

    // ---------------- apb register file ----------------
    contact_input_pkg::cfg_t cfg_q;
    logic [5:0]  sel_alarm_q;
    logic        out3_nc_q;
    logic        out3_sel_q;
    logic [15:0] read_delay_q;
    logic [15:0] off_time_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    wire         wr_en   = psel & penable & pwrite & pready_q;
    wire         setup   = psel & ~penable;
    wire         hit_cfg = paddr == `OFS_CFG;
    wire         hit_o3  = paddr == `OFS_OUT3;
    wire         hit_tm  = paddr == `OFS_TIMERS;
    wire         hit_cmd = paddr == `OFS_CMD;
    wire         hit_st  = paddr == `OFS_STATUS;
    wire         mapped  = hit_cfg | hit_o3 | hit_tm | hit_cmd | hit_st;
    wire [5:0]   sel_wr  = pwdata[`OUT3_SEL_HI:`OUT3_SEL_LO];
    wire         sel_ok  = sel_wr >= `SEL_FIRST && sel_wr <= `SEL_LAST;
    wire         clr_cmd = wr_en & hit_cmd & pwdata[`CMD_CLR_BIT];

    logic [31:0] rd_mux;
    logic [31:0] status_word;

    assign rd_mux = hit_cfg ? {20'h0, cfg_q} :
                    hit_o3  ? {19'h0, out3_sel_q, 3'h0, out3_nc_q,
                               2'h0, sel_alarm_q} :
                    hit_tm  ? {off_time_q, read_delay_q} :
                    hit_st  ? status_word : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~mapped;
            if (setup) begin
                prdata_q <= pwrite ? 32'h0 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q        <= contact_input_pkg::cfg_t'(`CFG_RST); // see R03 R04
            out3_nc_q    <= `POL_RST;                            // see R01
            out3_sel_q   <= 1'b0;
            sel_alarm_q  <= `SEL_RST;                            // see R02
            read_delay_q <= 16'(`TIMER_RST);                     // see R10
            off_time_q   <= 16'(`TIMER_RST >> 16);               // see R11
        end else if (wr_en) begin
            if (hit_cfg) begin
                cfg_q <= contact_input_pkg::cfg_t'(pwdata[11:0]);
            end
            if (hit_o3) begin
                out3_nc_q  <= pwdata[`OUT3_POL_BIT];             // see R01
                out3_sel_q <= pwdata[`OUT3_FUNC_BIT];
                // out of range or function bit not already stored before this write: number kept
                if (sel_ok && out3_sel_q) begin
                    sel_alarm_q <= sel_wr;                       // see R02
                end
            end
            if (hit_tm) begin
                read_delay_q <= pwdata[15:0];
                off_time_q   <= pwdata[31:16];
            end
        end
    end

    // ---------------- pin synchroniser and ms tick ----------------
    logic [1:0]  sync1_q;
    logic [1:0]  sync2_q;
    logic [1:0]  sync3_q;
    logic [1:0]  in_q;
    logic [1:0]  in_prev_q;
    logic [31:0] div_q;
    logic        tick_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q   <= 2'h0;
            sync2_q   <= 2'h0;
            sync3_q   <= 2'h0;
            in_q      <= 2'h0;
            in_prev_q <= 2'h0;
            div_q     <= 32'h0;
            tick_q    <= 1'b0;
        end else begin
            sync1_q   <= contact_in;
            sync2_q   <= sync1_q;
            sync3_q   <= sync2_q;
            // a change counts once the last two stages agree
            in_q      <= (sync2_q ~^ sync3_q) & sync3_q
                       | (sync2_q ^ sync3_q) & in_q;         // see R19
            in_prev_q <= in_q;
            tick_q    <= div_q == 32'(MS_CYCLES - 1);        // see R19
            div_q     <= (div_q == 32'(MS_CYCLES - 1)) ? 32'h0 : div_q + 32'h1;
        end
    end

    // ---------------- per input hold timer and release ----------------
    logic [1:0] held;
    logic [1:0] release_ok;
    logic [1:0] sw_off;
    logic [1:0] sw_en;
    logic [1:0] sw_detect;

    function automatic logic is_sw(contact_input_pkg::in_func_t f);
        return f == contact_input_pkg::FN_SW_NO ||
               f == contact_input_pkg::FN_SW_NC;
    endfunction

    wire contact_input_pkg::in_func_t fn [2] = '{cfg_q.in1_func,
                                                 cfg_q.in2_func};
    wire sw1_mode_ok = cfg_q.comm == contact_input_pkg::LOCAL_COMM_MODE ||
                       cfg_q.comm == contact_input_pkg::SERIAL_COMM_MODE &&
                       cfg_q.proto != contact_input_pkg::PROTO_SIMPLE2;
    wire supervising;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_in
            logic [15:0] hold_q;
            logic [15:0] off_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    hold_q <= 16'h0;
                    off_q  <= 16'h0;
                end else begin
                    if (!in_q[gi]) begin
                        hold_q <= 16'h0;
                    end else if (tick_q && !held[gi]) begin
                        hold_q <= hold_q + 16'h1;            // see R07 R19
                    end
                    if (!(supervising && sw_en[gi] && sw_off[gi])) begin
                        off_q <= 16'h0;                      // see R20
                    end else if (tick_q && off_q != 16'hffff) begin
                        off_q <= off_q + 16'h1;              // see R11
                    end
                end
            end
            assign held[gi]       = hold_q >= `HOLD_MS;
            assign release_ok[gi] = in_prev_q[gi] & ~in_q[gi] & held[gi];
            // normally closed switch is off when its contact is closed
            assign sw_off[gi]     = (fn[gi] == contact_input_pkg::FN_SW_NC)
                                    ? in_q[gi] : ~in_q[gi];  // see R18
            assign sw_en[gi]      = is_sw(fn[gi]) &&
                                    (gi == 1 || sw1_mode_ok); // see R16
            assign sw_detect[gi]  = supervising && sw_en[gi] && sw_off[gi]
                                    && off_q >= off_time_q;  // see R11 R14
        end
    endgenerate

    // ---------------- run/stop and remote select ----------------
    wire run1_lvl = cfg_q.in1_func == contact_input_pkg::FN_RUN_LEVEL;
    wire run1_tog = cfg_q.in1_func == contact_input_pkg::FN_RUN_TOG;
    wire run2_lvl = cfg_q.in2_func == contact_input_pkg::FN_RUN_LEVEL;
    wire run2_tog = cfg_q.in2_func == contact_input_pkg::FN_RUN_TOG;
    wire rmt_lvl  = cfg_q.in2_func == contact_input_pkg::FN_RMT_LEVEL;
    wire rmt_tog  = cfg_q.in2_func == contact_input_pkg::FN_RMT_TOG;
    wire use1     = run1_lvl | run1_tog;
    wire run_lvl  = use1 ? run1_lvl : run2_lvl;
    wire run_tog  = use1 ? run1_tog : run2_tog;
    wire run_pin  = use1 ? in_q[0] : in_q[1];
    wire run_rel  = use1 ? release_ok[0] : release_ok[1];

    logic run_req_q;
    logic remote_q;
    logic alarm_q;
    logic stop_lock_q;
    logic out3_q;
    logic run_req_d;
    logic stop_lock_d;
    logic running_q;
    contact_input_pkg::run_state_t state_q;
    logic [15:0] delay_q;

    // no run function: request frozen, contacts have no say
    assign run_req_d = run_lvl ? run_pin :                        // see R05
                       run_tog ? run_req_q ^ run_rel :            // see R06
                       run_req_q;                                 // see R15
    wire run_now     = run_req_q & ~stop_lock_q;
    wire detect      = |sw_detect &&
                       cfg_q.action != contact_input_pkg::ACT_NONE; // see R17
    wire stop_act    = detect &&
                       cfg_q.action == contact_input_pkg::ACT_STOP; // see R12
    assign supervising = state_q == contact_input_pkg::ST_SUPV;
    // a new detection wins over a clear in the same cycle
    assign stop_lock_d = stop_act | (stop_lock_q & ~clr_cmd);     // see R12

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_req_q   <= 1'b0;
            remote_q    <= 1'b0;
            alarm_q     <= 1'b0;
            stop_lock_q <= 1'b0;
            running_q   <= 1'b0;
            out3_q      <= `POL_RST;
        end else begin
            run_req_q   <= run_req_d;
            remote_q    <= rmt_lvl ? in_q[1] :                    // see R08
                           rmt_tog ? remote_q ^ release_ok[1] :   // see R09
                           1'b0;
            // a new detection wins over a clear in the same cycle
            alarm_q     <= detect | (alarm_q & ~clr_cmd);         // see R12
            stop_lock_q <= stop_lock_d;                           // see R12
            // registered copy of run_now, same cycle as the two flops
            running_q   <= run_req_d & ~stop_lock_d;
            out3_q      <= (out3_sel_q ? alarm_q &&
                            sel_alarm_q == `ALARM_SWITCH : alarm_q)
                           ^ out3_nc_q;                           // see R01
        end
    end

    // ---------------- supervision sequencer ----------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= contact_input_pkg::ST_STOP;
            delay_q <= 16'h0;
        end else begin
            case (state_q)
                contact_input_pkg::ST_STOP: begin
                    delay_q <= 16'h0;
                    if (run_now) begin
                        state_q <= contact_input_pkg::ST_DELAY;
                    end
                end
                contact_input_pkg::ST_DELAY: begin
                    if (!run_now) begin
                        state_q <= contact_input_pkg::ST_STOP;  // see R14
                    end else if (delay_q >= read_delay_q) begin
                        state_q <= contact_input_pkg::ST_SUPV;  // see R10
                    end else if (tick_q) begin
                        delay_q <= delay_q + 16'h1;
                    end
                end
                contact_input_pkg::ST_SUPV: begin
                    if (!run_now) begin
                        state_q <= contact_input_pkg::ST_STOP;  // see R13 R14
                    end
                end
                default: state_q <= contact_input_pkg::ST_STOP;
            endcase
        end
    end

    assign status_word = {24'h0, in_q, state_q == contact_input_pkg::ST_SUPV,
                          stop_lock_q, alarm_q, remote_q, run_now, 1'b0};

    assign prdata               = prdata_q;
    assign pready               = pready_q;
    assign pslverr              = pslverr_q;
    assign running              = running_q;
    assign contact_remote_state = remote_q;
    assign switch_detect_alarm  = alarm_q;
    assign contact_out3         = out3_q;

    // ---------------- assertions ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_level_run_follow: assert property (   // see R05
        run1_lvl && $stable(cfg_q) |=> run_req_q == $past(in_q[0]))
        else $error("level run request does not follow input");
    a_toggle_flip: assert property (        // see R06
        run1_tog && release_ok[0] |=> run_req_q != $past(run_req_q))
        else $error("toggle release did not flip run request");
    a_short_press: assert property (        // see R07
        run1_tog && in_prev_q[0] && !in_q[0] && !held[0]
        |=> run_req_q == $past(run_req_q))
        else $error("short press toggled run request");
    a_remote_level: assert property (       // see R08
        rmt_lvl ##1 rmt_lvl |-> remote_q == $past(in_q[1]))
        else $error("remote state does not follow input two");
    a_remote_toggle: assert property (      // see R09
        rmt_tog && release_ok[1] |=> remote_q != $past(remote_q))
        else $error("remote toggle missed");
    a_delay_gate: assert property (         // see R10
        state_q == contact_input_pkg::ST_DELAY && delay_q < read_delay_q
        |=> state_q != contact_input_pkg::ST_SUPV)
        else $error("supervision began before read delay");
    a_idle_no_supv: assert property (       // see R14
        !running |=> !supervising)
        else $error("supervising while stopped");
    a_stop_no_alarm: assert property (      // see R13
        !supervising && !switch_detect_alarm |=> !switch_detect_alarm)
        else $error("alarm raised outside supervision");
    a_alarm_stops: assert property (        // see R12
        stop_act |=> !running ##1 switch_detect_alarm)
        else $error("alarm with stop action kept running");
    a_off_restart: assert property (        // see R20
        supervising && sw_en[1] && !sw_off[1] |=> g_in[1].off_q == 16'h0)
        else $error("off count not restarted");
    a_no_source: assert property (          // see R15
        !use1 && !run2_lvl && !run2_tog |=> $stable(run_req_q))
        else $error("run changed with no run function");

    c_toggle_run:  cover property (run1_tog && release_ok[0]);
    c_alarm_stop:  cover property (stop_act ##1 !running);
    c_remote_tog:  cover property (rmt_tog && release_ok[1]);
    c_supervise:   cover property (state_q == contact_input_pkg::ST_DELAY
                                   ##1 supervising);

endmodule // contact_input_run_control

// ==== verification/contact_partner.sv ====
// customer contact and supervision switch model on the two contact inputs
`timescale 1ns/1ps
`include "contact_input_map.svh"

module contact_partner #(
    parameter int MS_CYCLES = 10
) (
    // clock
    input  wire logic       pclk,
    // contact pins, open contact reads low
    output logic      [1:0] contact_in
);
    initial contact_in = 2'h0;

    task automatic level(input int idx, input logic v);
        @(posedge pclk);
        contact_in[idx] <= v;
    endtask

    // shorter presses would be ignored by the toggle logic
    task automatic press(input int idx);
        level(idx, 1'b1);
        repeat (int'(`HOLD_MS) * MS_CYCLES + MS_CYCLES) @(posedge pclk);
        level(idx, 1'b0);
    endtask
endmodule // contact_partner

// ==== verification/testbench.sv ====
// self-checking bench for the contact input run control block
`timescale 1ns/1ps
`include "contact_input_map.svh"

module testbench;
    localparam int MS = 10;
    localparam int T_OFF = 4;
    localparam logic [31:0] ALL = 32'hffff_ffff;
    localparam logic [2:0] F_OFF = 3'h0;
    localparam logic [2:0] F_RL  = 3'h1;
    localparam logic [2:0] F_RT  = 3'h2;
    localparam logic [2:0] F_NO  = 3'h3;
    localparam logic [2:0] F_NC  = 3'h4;
    localparam logic [2:0] F_ML  = 3'h5;
    localparam logic [2:0] F_MT  = 3'h6;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  contact_in;
    logic        running;
    logic        contact_remote_state;
    logic        switch_detect_alarm;
    logic        contact_out3;
    logic [64:0] exp_q[$];
    logic [64:0] note;
    int          err_total;
    int          checks_done;
    int          dly;

    contact_input_run_control #(.MS_CYCLES(MS)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .contact_in(contact_in),
        .running(running), .contact_remote_state(contact_remote_state),
        .switch_detect_alarm(switch_detect_alarm),
        .contact_out3(contact_out3));

    contact_partner #(.MS_CYCLES(MS)) pm (
        .pclk(pclk), .contact_in(contact_in));

    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // entered right after a rising edge, leaves one idle cycle behind
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk(n == 1, "pready not in first access cycle");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic er);
        exp_q.push_back({er, m, e});
        apb(1'b0, a, 32'h0);
    endtask

    function automatic logic [31:0] cfg(input logic [2:0] f2, f1,
                                        input logic [1:0] c, a);
        return {20'h0, f2, f1, c, 2'h0, a};
    endfunction

    // read results are judged here against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
            note = exp_q.pop_front();
            chk(((prdata ^ note[31:0]) & note[63:32]) === 32'h0
                && pslverr === note[64], "read data or error flag");
        end
    end

    // run input is the other contact; switch starts at sw_v
    task automatic supv(input logic [31:0] c, input int sw,
                        input logic sw_v, input logic al, input logic ra);
        wr(`OFS_CMD, 32'h1);
        wr(`OFS_CFG, c);
        pm.level(sw, sw_v);
        pm.level(1 - sw, 1'b1);
        cyc((dly + T_OFF - 2) * MS);
        chk(switch_detect_alarm === 1'b0, "alarm too early");
        cyc(5 * MS);
        chk(switch_detect_alarm === al, "alarm after off time");
        chk(running === ra, "run after alarm");
        pm.level(1 - sw, 1'b0);
        pm.level(sw, 1'b0);
        cyc(MS);
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        end_of_test();
    end

    initial begin
        void'($urandom(2150));
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        err_total = 0;
        checks_done = 0;
        dly = 2 + int'($urandom % 4);
        cyc(3);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(contact_out3 === 1'b1 && running === 1'b0, "reset pins");
        rd(`OFS_CFG, {20'h0, `CFG_RST}, ALL, 1'b0);
        rd(`OFS_OUT3, 32'h0000_0101, ALL, 1'b0);
        rd(`OFS_TIMERS, `TIMER_RST, ALL, 1'b0);
        rd(12'h014, 32'h0, ALL, 1'b1);
        wr(`OFS_OUT3, 32'h0000_0124);
        rd(`OFS_OUT3, 32'h0000_0101, ALL, 1'b0);
        wr(`OFS_OUT3, 32'h0000_1101);
        wr(`OFS_OUT3, 32'h0000_1124);
        rd(`OFS_OUT3, 32'h0000_1124, ALL, 1'b0);
        wr(`OFS_OUT3, 32'h0000_1125);
        rd(`OFS_OUT3, 32'h0000_1124, ALL, 1'b0);
        wr(`OFS_OUT3, 32'h0000_1020);
        cyc(2);
        chk(contact_out3 === 1'b0, "open polarity idle");
        for (int c = 0; c < 3; c++) begin
            wr(`OFS_CFG, cfg(F_OFF, F_RL, c[1:0], 2'h0));
            rd(`OFS_CFG, cfg(F_OFF, F_RL, c[1:0], 2'h0), ALL, 1'b0);
        end
        wr(`OFS_CFG, cfg(F_OFF, F_RL, 2'h0, 2'h0));
        pm.level(0, 1'b1);
        cyc(MS);
        chk(running === 1'b1, "level run");
        pm.level(0, 1'b0);
        cyc(MS);
        chk(running === 1'b0, "level stop");
        wr(`OFS_CFG, cfg(F_OFF, F_OFF, 2'h0, 2'h0));
        pm.level(0, 1'b1);
        cyc(MS);
        chk(running === 1'b0, "no run function");
        pm.level(0, 1'b0);
        wr(`OFS_CFG, cfg(F_OFF, F_RT, 2'h0, 2'h0));
        pm.level(0, 1'b1);
        cyc(int'(`HOLD_MS) * MS + MS);
        chk(running === 1'b0, "toggle acts on release");
        pm.level(0, 1'b0);
        cyc(MS);
        chk(running === 1'b1, "toggle start");
        pm.press(0);
        cyc(MS);
        chk(running === 1'b0, "toggle stop");
        wr(`OFS_CFG, cfg(F_ML, F_OFF, 2'h0, 2'h0));
        pm.level(1, 1'b1);
        cyc(MS);
        chk(contact_remote_state === 1'b1, "remote level");
        pm.level(1, 1'b0);
        cyc(MS);
        chk(contact_remote_state === 1'b0, "local level");
        wr(`OFS_CFG, cfg(F_MT, F_OFF, 2'h0, 2'h0));
        pm.press(1);
        cyc(MS);
        rd(`OFS_STATUS, 32'h4, 32'h4, 1'b0);
        wr(`OFS_TIMERS, {16'(T_OFF), 16'(dly)});
        supv(cfg(F_NO, F_RL, 2'h0, 2'h0), 1, 1'b0, 1'b1, 1'b0);
        chk(contact_out3 === 1'b1, "selected alarm out");
        rd(`OFS_STATUS, 32'h8, 32'h8, 1'b0);
        supv(cfg(F_NC, F_RL, 2'h1, 2'h0), 1, 1'b1, 1'b1, 1'b0);
        supv(cfg(F_NO, F_RL, 2'h0, 2'h1), 1, 1'b0, 1'b1, 1'b1);
        supv(cfg(F_NO, F_RL, 2'h0, 2'h2), 1, 1'b0, 1'b0, 1'b1);
        supv(cfg(F_RL, F_NO, 2'h1, 2'h0), 0, 1'b0, 1'b0, 1'b1);
        supv(cfg(F_RL, F_NO, 2'h2, 2'h0), 0, 1'b0, 1'b1, 1'b0);
        supv(cfg(F_RL, F_NO, 2'h2, 2'h0) | 32'h8, 0, 1'b0, 1'b0, 1'b1);
        wr(`OFS_CMD, 32'h1);
        wr(`OFS_CFG, cfg(F_NO, F_RL, 2'h0, 2'h0));
        pm.level(1, 1'b1);
        pm.level(0, 1'b1);
        cyc((dly + 1) * MS);
        for (int k = 0; k < 2; k++) begin
            pm.level(1, 1'b0);
            cyc(2 * MS);
            pm.level(1, 1'b1);
            cyc(MS);
        end
        chk(switch_detect_alarm === 1'b0, "off count restart");
        pm.level(1, 1'b0);
        cyc((T_OFF + 2) * MS);
        chk(switch_detect_alarm === 1'b1, "off detected");
        wr(`OFS_CMD, 32'h1);
        pm.level(1, 1'b1);
        pm.level(0, 1'b0);
        pm.level(0, 1'b1);
        cyc(2 * MS);
        pm.level(0, 1'b0);
        cyc(MS);
        pm.level(1, 1'b0);
        cyc((dly + T_OFF + 3) * MS);
        chk(switch_detect_alarm === 1'b0, "no alarm when stopped");
        end_of_test();
    end
endmodule // testbench
